// file: pvsir_chk.sv
// Assertion checker for the vendor register bank
module pvsir_chk
  import pvsir_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Register access
  input wire logic [4:0] reg_index,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // Outputs
  input wire logic auto_crossover_disable,
  input wire logic crossover_swapped,
  input wire logic interrupt_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================
  // Read decodes
  logic rd_ok, rd_x, rd_f, rd_m, rd_s, rd_bad;
  assign rd_ok = reg_read && !reg_write;
  assign rd_x = rd_ok && reg_index == IDX_CROSSOVER_POLARITY_CONTROL;
  assign rd_f = rd_ok && reg_index == IDX_INTERRUPT_SOURCE_FLAGS;
  assign rd_m = rd_ok && reg_index == IDX_INTERRUPT_ENABLE_MASK;
  assign rd_s = rd_ok && reg_index == IDX_NEGOTIATION_RESULT_STATUS;
  assign rd_bad = reg_read && !(reg_index inside {5'h1a, 5'h1b, 5'h1d, 5'h1e, 5'h1f});
  // ==========================================
  // Assertions
  // Swap output is registered from the control bits, so it trails them by one cycle
  a_swap_needs_manual: assert property (crossover_swapped |-> $past(auto_crossover_disable))
    else $error("swap without manual mode");
  a_xover_readback: assert property (rd_x |=> reg_rdata[15] == $past(auto_crossover_disable))
    else $error("crossover bit readback wrong");
  a_xover_reserved: assert property (rd_x |=> reg_rdata[14] == 1'b0 && reg_rdata[12:5] == 8'h00)
    else $error("crossover reserved bits set");
  a_mask_reserved: assert property (rd_m |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[0])
    else $error("mask reserved bits set");
  a_flag_reserved: assert property (rd_f |=> reg_rdata[15:8] == 8'h00 && !reg_rdata[0])
    else $error("flag reserved bits set");
  a_status_reserved: assert property (rd_s |=> reg_rdata[15:13] == 3'h0 && reg_rdata[1:0] == 2'h0)
    else $error("status reserved bits set");
  a_unknown_zero: assert property (rd_bad |=> reg_rdata == 16'h0000)
    else $error("unknown index read nonzero");
  a_rdata_holds: assert property (!reg_read |=> $stable(reg_rdata))
    else $error("read data changed without read");
  a_irq_masked: assert property (rd_m ##1 (reg_rdata[7:1] == 7'h00 && !reg_write) |=> !interrupt_out)
    else $error("interrupt with all sources masked");
  c_irq: cover property ($rose(interrupt_out));
  c_swap: cover property ($rose(crossover_swapped));
  c_flags: cover property (rd_f ##1 reg_rdata[7:1] != 7'h00);
endmodule

bind pvsir_regs pvsir_chk u_chk (.ref_clk, .reset_n, .reg_index, .reg_write, .reg_read, .reg_rdata,
  .auto_crossover_disable, .crossover_swapped, .interrupt_out);

// file: pvsir_energy_timer.sv
// Line energy presence timer
module pvsir_energy_timer
  import pvsir_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = ENERGY_TIMEOUT_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Energy input, already synchronised
  input wire logic energy_seen,
  // Status
  output logic line_energy_present
);
  logic [ENERGY_COUNT_W-1:0] idle_count_reg;

  // ==========================================
  // Quiet time counter
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idle_count_reg <= '0;
      line_energy_present <= 1'b1;
    end
    else if (energy_seen)
    begin
      idle_count_reg <= '0;
      line_energy_present <= 1'b1;
    end
    else if (idle_count_reg >= ENERGY_COUNT_W'(TIMEOUT_CYCLES - 1))
    begin
      line_energy_present <= 1'b0;
    end
    else
    begin
      idle_count_reg <= idle_count_reg + 1'b1;
    end
  end
endmodule

// file: pvsir_mgmt_model.sv
// Management controller model for the register access port
module pvsir_mgmt_model
  import pvsir_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Register access
  output logic [4:0] reg_index,
  output logic reg_write,
  output logic reg_read,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    reg_index = 5'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 16'h0000;
  end
  // One-cycle write strobe
  task automatic wr(input logic [4:0] idx, input logic [15:0] dat);
    @(posedge ref_clk);
    #1;
    reg_index = idx;
    reg_wdata = dat;
    if (idx == IDX_NEGOTIATION_RESULT_STATUS)
      reg_wdata[RSVD_HI:RSVD_LO] = RSVD_STATUS_RESET;
    reg_write = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_write = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask
  // One-cycle read strobe, data taken a cycle later
  task automatic rd(input logic [4:0] idx, output logic [15:0] dat);
    @(posedge ref_clk);
    #1;
    reg_index = idx;
    reg_read = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_read = 1'b0;
    dat = reg_rdata;
  endtask
endmodule

// file: pvsir_pkg.sv
// Constants for the vendor status and interrupt register bank
// Operation
// - Count bad 100TX symbols, idles included
// - At most one count per packet
// - Count wraps from maximum to zero
// - Count resets zero, reading never clears
// - No counting in 10BASE-T mode
// - Bit 15 one disables auto crossover
// - Manual select: zero MDI, one MDIX
// - Bit 4 reports reversed 10BASE-T polarity
// - Latch energy, negotiation done, remote fault
// - Latch link down, ack, fault, page
// - Mask bits enable sources, reset masked
// - Bit 12 shows negotiation done
// - Reserved bits 11:5 reset to 0000010b
// - Bits 4:2 encode speed and duplex
// - Energy status drops after 256 ms
package pvsir_pkg;
  // ==========================================
  // Register indexes
  localparam logic [4:0] IDX_SYMBOL_ERROR_COUNT = 5'h1a;
  localparam logic [4:0] IDX_CROSSOVER_POLARITY_CONTROL = 5'h1b;
  localparam logic [4:0] IDX_INTERRUPT_SOURCE_FLAGS = 5'h1d;
  localparam logic [4:0] IDX_INTERRUPT_ENABLE_MASK = 5'h1e;
  localparam logic [4:0] IDX_NEGOTIATION_RESULT_STATUS = 5'h1f;
  // ==========================================
  // Field positions
  localparam int AUTO_XOVER_DISABLE_BIT = 15;
  localparam int MANUAL_XOVER_SELECT_BIT = 13;
  localparam int RX_POLARITY_BIT = 4;
  localparam int NEG_DONE_BIT = 12;
  localparam int RSVD_HI = 11;
  localparam int RSVD_LO = 5;
  localparam int SPEED_HI = 4;
  localparam int SPEED_LO = 2;
  localparam int FLAG_HI = 7;
  localparam int FLAG_LO = 1;
  // ==========================================
  // Reset values
  localparam logic [15:0] SYMBOL_COUNT_RESET = 16'h0000;
  localparam logic [6:0] FLAGS_RESET = 7'h00;
  localparam logic [6:0] MASK_RESET = 7'h00;
  localparam logic [6:0] RSVD_STATUS_RESET = 7'h02;
  // ==========================================
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int ENERGY_TIMEOUT_MS = 256;
  localparam int ENERGY_TIMEOUT_CYCLES = (CLK_HZ / 1000) * ENERGY_TIMEOUT_MS;
  localparam int ENERGY_COUNT_W = 22;
endpackage

// file: pvsir_regs.sv
// Vendor status, crossover and interrupt register bank
module pvsir_regs
  import pvsir_pkg::*;
#(
  parameter int ENERGY_TIMEOUT = ENERGY_TIMEOUT_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Management register access
  input wire logic [4:0] reg_index,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Line side status from the receive logic
  input wire logic mode_100tx,
  input wire logic packet_end,
  input wire logic bad_symbol,
  input wire logic rx_polarity_in,
  input wire logic line_energy,
  input wire logic neg_done_in,
  input wire logic [2:0] speed_duplex_in,
  // Line side events
  input wire logic remote_fault_event,
  input wire logic link_lost_event,
  input wire logic partner_ack_event,
  input wire logic parallel_fault_event,
  input wire logic page_received_event,
  // Control, status and interrupt outputs
  output logic auto_crossover_disable,
  output logic crossover_swapped,
  output logic line_energy_present,
  output logic interrupt_out
);
  logic [1:0] energy_sync_reg;
  logic [1:0] polarity_sync_reg;
  logic [1:0] done_sync_reg;
  logic [2:0] speed_sync0_reg;
  logic [2:0] speed_sync1_reg;
  logic [15:0] bad_symbol_count;
  logic packet_bad_reg;
  logic manual_crossover_select;
  logic rx_polarity_reversed;
  logic [6:0] flags_reg;
  logic [6:0] mask_reg;
  logic [6:0] rsvd_status_reg;
  logic negotiation_done;
  logic [2:0] resolved_speed_duplex;
  logic energy_prev_reg;
  logic done_prev_reg;
  logic energy_present_w;
  logic [6:0] event_vec;
  logic flags_read;
  logic [15:0] rdata_next;

  function automatic logic hit(input logic [4:0] idx, input logic [4:0] want);
    hit = (idx == want);
  endfunction

  // ==========================================
  // Synchronisers for asynchronous line status
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      energy_sync_reg <= 2'h0;
      polarity_sync_reg <= 2'h0;
      done_sync_reg <= 2'h0;
      speed_sync0_reg <= 3'h0;
      speed_sync1_reg <= 3'h0;
    end
    else
    begin
      energy_sync_reg <= {energy_sync_reg[0], line_energy};
      polarity_sync_reg <= {polarity_sync_reg[0], rx_polarity_in};
      done_sync_reg <= {done_sync_reg[0], neg_done_in};
      speed_sync0_reg <= speed_duplex_in;
      speed_sync1_reg <= speed_sync0_reg;
    end
  end

  pvsir_energy_timer #(.TIMEOUT_CYCLES(ENERGY_TIMEOUT)) u_energy
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .energy_seen(energy_sync_reg[1]),
    .line_energy_present(energy_present_w)
  );

  // ==========================================
  // Status capture
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_polarity_reversed <= 1'b0;
      negotiation_done <= 1'b0;
      resolved_speed_duplex <= 3'h0;
      line_energy_present <= 1'b1;
      energy_prev_reg <= 1'b1;
      done_prev_reg <= 1'b0;
    end
    else
    begin
      rx_polarity_reversed <= polarity_sync_reg[1];
      negotiation_done <= done_sync_reg[1];
      resolved_speed_duplex <= speed_sync1_reg;
      line_energy_present <= energy_present_w;
      energy_prev_reg <= energy_present_w;
      done_prev_reg <= done_sync_reg[1];
    end
  end

  // ==========================================
  // Bad symbol counter
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bad_symbol_count <= SYMBOL_COUNT_RESET;
      packet_bad_reg <= 1'b0;
    end
    else if (!mode_100tx)
    begin
      packet_bad_reg <= 1'b0;
    end
    else
    begin
      // One mark per packet, counted when the packet ends
      if (packet_end)
      begin
        packet_bad_reg <= 1'b0;
        if (packet_bad_reg || bad_symbol)
        begin
          bad_symbol_count <= bad_symbol_count + 16'h0001;
        end
      end
      else if (bad_symbol)
      begin
        packet_bad_reg <= 1'b1;
      end
    end
  end

  // ==========================================
  // Crossover control
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      auto_crossover_disable <= 1'b0;
      manual_crossover_select <= 1'b0;
      crossover_swapped <= 1'b0;
    end
    else
    begin
      if (reg_write && hit(reg_index, IDX_CROSSOVER_POLARITY_CONTROL))
      begin
        auto_crossover_disable <= reg_wdata[AUTO_XOVER_DISABLE_BIT];
        manual_crossover_select <= reg_wdata[MANUAL_XOVER_SELECT_BIT];
      end
      // Manual channel only when auto crossover is off
      crossover_swapped <= auto_crossover_disable & manual_crossover_select;
    end
  end

  // ==========================================
  // Interrupt sources, mask and output
  assign event_vec = {energy_present_w & ~energy_prev_reg,
                      done_sync_reg[1] & ~done_prev_reg,
                      remote_fault_event,
                      link_lost_event,
                      partner_ack_event,
                      parallel_fault_event,
                      page_received_event};
  assign flags_read = reg_read && hit(reg_index, IDX_INTERRUPT_SOURCE_FLAGS);

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flags_reg <= FLAGS_RESET;
    end
    else if (flags_read)
    begin
      flags_reg <= event_vec;
    end
    else
    begin
      flags_reg <= flags_reg | event_vec;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_reg <= MASK_RESET;
    end
    else if (reg_write && hit(reg_index, IDX_INTERRUPT_ENABLE_MASK))
    begin
      mask_reg <= reg_wdata[FLAG_HI:FLAG_LO];
    end
  end

  // ==========================================
  // Reserved status field, stored as written
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsvd_status_reg <= RSVD_STATUS_RESET;
    end
    else if (reg_write && hit(reg_index, IDX_NEGOTIATION_RESULT_STATUS))
    begin
      rsvd_status_reg <= reg_wdata[RSVD_HI:RSVD_LO];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      interrupt_out <= 1'b0;
    end
    else
    begin
      interrupt_out <= |(flags_reg & mask_reg);
    end
  end

  // ==========================================
  // Read data, registered one cycle after the read strobe
  always_comb
  begin
    rdata_next = 16'h0000;
    unique case (reg_index)
      IDX_SYMBOL_ERROR_COUNT:
      begin
        rdata_next = bad_symbol_count;
      end
      IDX_CROSSOVER_POLARITY_CONTROL:
      begin
        rdata_next[AUTO_XOVER_DISABLE_BIT] = auto_crossover_disable;
        rdata_next[MANUAL_XOVER_SELECT_BIT] = manual_crossover_select;
        rdata_next[RX_POLARITY_BIT] = rx_polarity_reversed;
      end
      IDX_INTERRUPT_SOURCE_FLAGS:
      begin
        rdata_next[FLAG_HI:FLAG_LO] = flags_reg;
      end
      IDX_INTERRUPT_ENABLE_MASK:
      begin
        rdata_next[FLAG_HI:FLAG_LO] = mask_reg;
      end
      IDX_NEGOTIATION_RESULT_STATUS:
      begin
        rdata_next[NEG_DONE_BIT] = negotiation_done;
        rdata_next[RSVD_HI:RSVD_LO] = rsvd_status_reg;
        rdata_next[SPEED_HI:SPEED_LO] = resolved_speed_duplex;
      end
      default:
      begin
        rdata_next = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 16'h0000;
    end
    else if (reg_read)
    begin
      reg_rdata <= rdata_next;
    end
  end
endmodule

// file: tb.sv
// Testbench for the vendor register bank
module tb import pvsir_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, reset_n, mode_100tx, packet_end, bad_symbol, rx_polarity_in, line_energy, neg_done_in;
  logic [2:0] speed_duplex_in;
  logic [4:0] ev, reg_index;
  logic reg_write, reg_read, auto_crossover_disable, crossover_swapped, line_energy_present, interrupt_out;
  logic [15:0] reg_wdata, reg_rdata, d;
  int num_errors = 0;
  int n_checks = 0;
  // Rows: index, write data, expected read
  localparam logic [36:0] ROWS [5] = '{{5'h1a, 16'hffff, 16'h0000}, {5'h1b, 16'ha010, 16'ha000},
    {5'h1e, 16'hffff, 16'h00fe}, {5'h1f, 16'h0000, 16'h0058}, {5'h1c, 16'hffff, 16'h0000}};
  localparam logic [20:0] RST [5] = '{{5'h1a, 16'h0000}, {5'h1b, 16'h0000}, {5'h1d, 16'h0000},
    {5'h1e, 16'h0000}, {5'h1f, 16'h0058}};

  pvsir_regs #(.ENERGY_TIMEOUT(20)) DUT (.ref_clk, .reset_n, .reg_index, .reg_write, .reg_read, .reg_wdata,
    .reg_rdata, .mode_100tx, .packet_end, .bad_symbol, .rx_polarity_in, .line_energy, .neg_done_in,
    .speed_duplex_in, .remote_fault_event(ev[4]), .link_lost_event(ev[3]), .partner_ack_event(ev[2]),
    .parallel_fault_event(ev[1]), .page_received_event(ev[0]), .auto_crossover_disable, .crossover_swapped,
    .line_energy_present, .interrupt_out);
  pvsir_mgmt_model m (.ref_clk, .reg_index, .reg_write, .reg_read, .reg_wdata, .reg_rdata);

  always #50 ref_clk = ~ref_clk;

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One packet with bad symbols on every cycle, end included
  task pkt(input logic tx);
    @(posedge ref_clk);
    #1;
    mode_100tx = tx;
    bad_symbol = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    packet_end = 1'b1;
    @(posedge ref_clk);
    #1;
    {bad_symbol, packet_end, mode_100tx} = 3'b001;
  endtask
  // Returns just after the last edge, so callers drive off the edge
  task wait_n(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  initial
  begin
    #9ms;
    num_errors++;
    end_of_test();
  end

  initial
  begin
    {ref_clk, reset_n, packet_end, bad_symbol, rx_polarity_in, line_energy, neg_done_in} = 7'h00;
    mode_100tx = 1'b1;
    speed_duplex_in = 3'b110;
    ev = 5'h00;
    wait_n(12);
    chk(16'(line_energy_present), 16'h0001);
    chk(16'({interrupt_out, auto_crossover_disable, crossover_swapped}), 16'h0000);
    chk(reg_rdata, 16'h0000);
    reset_n = 1'b1;
    foreach (RST[i])
    begin
      m.rd(RST[i][20:16], d);
      chk(d, RST[i][15:0]);
    end
    foreach (ROWS[i])
    begin
      m.wr(ROWS[i][36:32], ROWS[i][31:16]);
      m.rd(ROWS[i][36:32], d);
      chk(d, ROWS[i][15:0]);
    end
    chk(16'({auto_crossover_disable, crossover_swapped}), 16'h0003);
    m.wr(5'h1b, 16'h2000);
    wait_n(2);
    chk(16'({auto_crossover_disable, crossover_swapped}), 16'h0000);
    rx_polarity_in = 1'b1;
    wait_n(5);
    m.rd(5'h1b, d);
    chk(d, 16'h2010);
    pkt(1'b1);
    m.rd(5'h1a, d);
    chk(d, 16'h0001);
    pkt(1'b0);
    m.rd(5'h1a, d);
    chk(d, 16'h0001);
    {bad_symbol, packet_end} = 2'b11;
    wait_n(65534);
    {bad_symbol, packet_end} = 2'b00;
    m.rd(5'h1a, d);
    chk(d, 16'hffff);
    pkt(1'b1);
    m.rd(5'h1a, d);
    chk(d, 16'h0000);
    chk(16'(line_energy_present), 16'h0000);
    {neg_done_in, line_energy} = 2'b11;
    ev = 5'h1f;
    wait_n(1);
    ev = 5'h00;
    wait_n(8);
    m.rd(5'h1d, d);
    chk(d, 16'h00fe);
    m.rd(5'h1d, d);
    chk(d, 16'h0000);
    // Event still high at the clearing read: the flag must survive it
    ev = 5'h01;
    m.rd(5'h1d, d);
    chk(d, 16'h0002);
    ev = 5'h00;
    m.rd(5'h1d, d);
    chk(d, 16'h0002);
    m.rd(5'h1d, d);
    chk(d, 16'h0000);
    m.rd(5'h1f, d);
    chk(d, 16'h1058);
    m.wr(5'h1e, 16'h0000);
    ev = 5'h08;
    wait_n(1);
    ev = 5'h00;
    wait_n(3);
    chk(16'(interrupt_out), 16'h0000);
    m.wr(5'h1e, 16'h0010);
    wait_n(3);
    chk(16'(interrupt_out), 16'h0001);
    m.rd(5'h1d, d);
    chk(d, 16'h0010);
    wait_n(3);
    chk(16'(interrupt_out), 16'h0000);
    // Mid-run reset with a counted packet, manual swap and lost energy
    pkt(1'b1);
    {line_energy, rx_polarity_in} = 2'b00;
    m.wr(5'h1b, 16'ha000);
    wait_n(30);
    chk(16'(line_energy_present), 16'h0000);
    chk(16'(crossover_swapped), 16'h0001);
    reset_n = 1'b0;
    wait_n(2);
    chk(16'({line_energy_present, interrupt_out, auto_crossover_disable, crossover_swapped}), 16'h0008);
    reset_n = 1'b1;
    m.rd(5'h1a, d);
    chk(d, 16'h0000);
    m.rd(5'h1b, d);
    chk(d, 16'h0000);
    end_of_test();
  end
endmodule
